// ---- verilog/pdo_pkg.sv ----
// constants for the port d / port e alternate-function override block
// assumes a 32-bit apb slave with word-aligned registers
package pdo_pkg;
  localparam int ADDR_W = 12;
  localparam int PD_W = 8;
  localparam int PE_W = 3;
  // register byte offsets
  localparam logic [11:0] OFS_PD_DATA = 12'h000;
  localparam logic [11:0] OFS_PD_DIR = 12'h004;
  localparam logic [11:0] OFS_PD_PIN = 12'h008;
  localparam logic [11:0] OFS_PE_DATA = 12'h00C;
  localparam logic [11:0] OFS_PE_DIR = 12'h010;
  localparam logic [11:0] OFS_PE_PIN = 12'h014;
  localparam logic [11:0] OFS_CTRL = 12'h018;
  localparam logic [11:0] OFS_DRIVE = 12'h01C;
  // control register fields
  localparam int CTRL_EXT_MEM = 0;
  localparam int CTRL_ASYNC_T2 = 1;
  localparam int CTRL_PULLUP_DIS = 2;
  localparam int CTRL_W = 3;
  // drive status fields: port d output enables then port e output enables
  localparam int DRV_PD_LSB = 0;
  localparam int DRV_PE_LSB = 8;
  // reset values
  localparam logic [7:0] RST_PD = 8'h00;
  localparam logic [2:0] RST_PE = 3'h0;
  localparam logic [2:0] RST_CTRL = 3'h0;
  // pin positions
  localparam int PD_RD = 7;
  localparam int PD_WR = 6;
  localparam int PD_OSC_OUT = 5;
  localparam int PD_OSC_IN = 4;
  localparam int PD_IRQ1 = 3;
  localparam int PD_IRQ0 = 2;
  localparam int PD_TX = 1;
  localparam int PD_RX = 0;
  localparam int PE_CMP_B = 2;
  localparam int PE_ALE = 1;
  localparam int PE_IRQ2 = 0;
endpackage

// ---- verilog/pdo_port_de.sv ----
// port d (8 pins) and port e (3 pins) alternate-function override logic
// assumes peripheral controls come from logic on mclk; pad inputs are asynchronous
//
// Overview of operation
// - async timer2 clocking turns pin d5 into the oscillator amplifier output
// - async timer2 clocking turns pin d4 into the oscillator amplifier input
// - ext memory forces d7,d6 output strobes; async clocking forces d5,d4 input, no pull-up
// - timer1 compare a drives d5 output value; shows only when its direction bit set
// - serial0 clock on d4 is output with direction 1, input otherwise, sync mode only
// - d4 value taken by serial0 clock or timer3 compare a; serial clock wins
// - d3 feeds irq1 and timer3 capture; input enable forced when irq1 enabled
// - serial1 clock on d2 is output with direction 1, input otherwise, sync mode only
// - serial0 transmit enabled forces d1 output, no pull-up, driving transmit data
// - serial0 receive enabled forces d0 input and feeds the receiver
// - while receiver forces d0 input, pull-up follows port data bit and global disable
// - d3,d2 pull-up and direction never overridden; d2 value by serial1 clock output
// - timer1 compare b drives e2 output value only; pin must be set output
// - ext memory forces e1 output driving address latch enable; e2,e0 untouched
// - e0 feeds irq2 and timer1 capture; input enable forced when irq2 enabled
// - d7 strobe in ext memory mode is the external data read control
`timescale 1ns/1ns
module pdo_port_de (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic mem_rd_strobe,
  input wire logic mem_wr_strobe,
  input wire logic mem_ale,
  input wire logic t1_cmp_a_en,
  input wire logic t1_cmp_a_out,
  input wire logic t1_cmp_b_en,
  input wire logic t1_cmp_b_out,
  input wire logic t3_cmp_a_en,
  input wire logic t3_cmp_a_out,
  input wire logic ser0_sync_mode,
  input wire logic ser0_ext_clk_out,
  input wire logic ser1_sync_mode,
  input wire logic ser1_ext_clk_out,
  input wire logic ser0_tx_enable,
  input wire logic ser0_tx_line,
  input wire logic ser0_rx_enable,
  input wire logic ext_irq0_en,
  input wire logic ext_irq1_en,
  input wire logic ext_irq2_en,
  output logic ser0_rx_line,
  output logic ser0_ext_clk_in,
  output logic ser1_ext_clk_in,
  output logic ext_irq0,
  output logic ext_irq1,
  output logic ext_irq2,
  output logic t1_capture_in,
  output logic t3_capture_in,
  output logic xtal_osc_connect,
  input wire logic [7:0] pd_in,
  output logic [7:0] pd_out,
  output logic [7:0] pd_oe,
  output logic [7:0] pd_pullup,
  input wire logic [2:0] pe_in,
  output logic [2:0] pe_out,
  output logic [2:0] pe_oe,
  output logic [2:0] pe_pullup
);

  // override enable selects override value, else the port-register value
  function automatic logic pick(input logic en, input logic val, input logic normal);
    pick = en ? val : normal;
  endfunction

  logic rst_meta, rst_n;
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // pad synchronisers: first stage read only by the second
  logic [7:0] pd_meta, pd_sync;
  logic [2:0] pe_meta, pe_sync;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_meta <= 8'h00;
      pd_sync <= 8'h00;
      pe_meta <= 3'h0;
      pe_sync <= 3'h0;
    end else begin
      pd_meta <= pd_in;
      pd_sync <= pd_meta;
      pe_meta <= pe_in;
      pe_sync <= pe_meta;
    end
  end

  // register file
  logic [7:0] pd_data, pd_dir;
  logic [2:0] pe_data, pe_dir, ctrl;
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_pd_data = paddr == pdo_pkg::OFS_PD_DATA;
  wire hit_pd_dir = paddr == pdo_pkg::OFS_PD_DIR;
  wire hit_pd_pin = paddr == pdo_pkg::OFS_PD_PIN;
  wire hit_pe_data = paddr == pdo_pkg::OFS_PE_DATA;
  wire hit_pe_dir = paddr == pdo_pkg::OFS_PE_DIR;
  wire hit_pe_pin = paddr == pdo_pkg::OFS_PE_PIN;
  wire hit_ctrl = paddr == pdo_pkg::OFS_CTRL;
  wire hit_drive = paddr == pdo_pkg::OFS_DRIVE;
  wire hit_any = hit_pd_data || hit_pd_dir || hit_pd_pin || hit_pe_data || hit_pe_dir
                 || hit_pe_pin || hit_ctrl || hit_drive;
  wire wr_en = access_ph && pwrite;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_data <= pdo_pkg::RST_PD;
      pd_dir <= pdo_pkg::RST_PD;
      pe_data <= pdo_pkg::RST_PE;
      pe_dir <= pdo_pkg::RST_PE;
      ctrl <= pdo_pkg::RST_CTRL;
    end else if (wr_en) begin
      if (hit_pd_data) pd_data <= pwdata[7:0];
      if (hit_pd_dir) pd_dir <= pwdata[7:0];
      if (hit_pe_data) pe_data <= pwdata[2:0];
      if (hit_pe_dir) pe_dir <= pwdata[2:0];
      if (hit_ctrl) ctrl <= pwdata[2:0];
    end
  end

  wire ext_mem_enable = ctrl[pdo_pkg::CTRL_EXT_MEM];
  wire async_timer2_clk = ctrl[pdo_pkg::CTRL_ASYNC_T2];
  wire global_pullup_term = ctrl[pdo_pkg::CTRL_PULLUP_DIS];

  // per-pin override enables and values, port d
  logic [7:0] pd_pu_en, pd_pu_val, pd_dir_en, pd_dir_val;
  logic [7:0] pd_ov_en, pd_ov_val, pd_ie_en, pd_ie_val;
  wire ser0_clk_oe = ser0_sync_mode && pd_dir[pdo_pkg::PD_OSC_IN];
  wire ser1_clk_oe = ser1_sync_mode && pd_dir[pdo_pkg::PD_IRQ0];
  wire portd_bit0_data = pd_data[pdo_pkg::PD_RX];

  always_comb begin
    // d7/d6: memory strobes
    pd_pu_en[7:6] = {2{ext_mem_enable}};
    pd_pu_val[7:6] = 2'h0;
    pd_dir_en[7:6] = {2{ext_mem_enable}};
    pd_dir_val[7:6] = 2'h3;
    pd_ov_en[7:6] = {2{ext_mem_enable}};
    pd_ov_val[7:6] = {mem_rd_strobe, mem_wr_strobe};
    pd_ie_en[7:6] = 2'h0;
    pd_ie_val[7:6] = 2'h0;
    // d5/d4: oscillator pins under async clocking, else compare and serial clock
    pd_pu_en[5:4] = {2{async_timer2_clk}};
    pd_pu_val[5:4] = 2'h0;
    pd_dir_en[5:4] = {2{async_timer2_clk}};
    pd_dir_val[5:4] = 2'h0;
    pd_ie_en[5:4] = {2{async_timer2_clk}};
    pd_ie_val[5:4] = 2'h0;
    pd_ov_en[5] = t1_cmp_a_en;
    pd_ov_val[5] = t1_cmp_a_out;
    pd_ov_en[4] = ser0_clk_oe || t3_cmp_a_en;
    pd_ov_val[4] = ser0_clk_oe ? ser0_ext_clk_out : t3_cmp_a_out;
    // d3/d2: interrupts, never pull-up or direction overridden
    pd_pu_en[3:2] = 2'h0;
    pd_pu_val[3:2] = 2'h0;
    pd_dir_en[3:2] = 2'h0;
    pd_dir_val[3:2] = 2'h0;
    pd_ov_en[3] = 1'b0;
    pd_ov_val[3] = 1'b0;
    pd_ov_en[2] = ser1_clk_oe;
    pd_ov_val[2] = ser1_ext_clk_out;
    pd_ie_en[3:2] = {ext_irq1_en, ext_irq0_en};
    pd_ie_val[3:2] = 2'h3;
    // d1: transmit
    pd_pu_en[1] = ser0_tx_enable;
    pd_pu_val[1] = 1'b0;
    pd_dir_en[1] = ser0_tx_enable;
    pd_dir_val[1] = 1'b1;
    pd_ov_en[1] = ser0_tx_enable;
    pd_ov_val[1] = ser0_tx_line;
    pd_ie_en[1] = 1'b0;
    pd_ie_val[1] = 1'b0;
    // d0: receive; pull-up still software-controlled
    pd_pu_en[0] = ser0_rx_enable;
    pd_pu_val[0] = portd_bit0_data && !global_pullup_term;
    pd_dir_en[0] = ser0_rx_enable;
    pd_dir_val[0] = 1'b0;
    pd_ov_en[0] = 1'b0;
    pd_ov_val[0] = 1'b0;
    pd_ie_en[0] = 1'b0;
    pd_ie_val[0] = 1'b0;
  end

  // port e overrides
  logic [2:0] pe_pu_en, pe_dir_en, pe_ov_en, pe_ov_val, pe_ie_en;
  always_comb begin
    pe_pu_en = {1'b0, ext_mem_enable, 1'b0};
    pe_dir_en = {1'b0, ext_mem_enable, 1'b0};
    pe_ov_en = {t1_cmp_b_en, ext_mem_enable, 1'b0};
    pe_ov_val = {t1_cmp_b_out, mem_ale, 1'b0};
    pe_ie_en = {2'h0, ext_irq2_en};
  end

  // merge with port registers; pull-up needs input direction and no global disable
  logic [7:0] next_pd_out, next_pd_oe, next_pd_pullup, pd_inen;
  logic [2:0] next_pe_out, next_pe_oe, next_pe_pullup, pe_inen;
  always_comb begin
    for (int i = 0; i < pdo_pkg::PD_W; i++) begin
      next_pd_out[i] = pick(pd_ov_en[i], pd_ov_val[i], pd_data[i]);
      next_pd_oe[i] = pick(pd_dir_en[i], pd_dir_val[i], pd_dir[i]);
      next_pd_pullup[i] = pick(pd_pu_en[i], pd_pu_val[i],
                               pd_data[i] && !pd_dir[i] && !global_pullup_term);
      pd_inen[i] = pick(pd_ie_en[i], pd_ie_val[i], 1'b1);
    end
    for (int j = 0; j < pdo_pkg::PE_W; j++) begin
      next_pe_out[j] = pick(pe_ov_en[j], pe_ov_val[j], pe_data[j]);
      next_pe_oe[j] = pick(pe_dir_en[j], 1'b1, pe_dir[j]);
      next_pe_pullup[j] = pick(pe_pu_en[j], 1'b0,
                               pe_data[j] && !pe_dir[j] && !global_pullup_term);
      pe_inen[j] = pick(pe_ie_en[j], 1'b1, 1'b1);
    end
  end

  // a disabled digital input reads as zero so a floating crystal pin draws no current
  wire [7:0] pd_pin = pd_sync & pd_inen;
  wire [2:0] pe_pin = pe_sync & pe_inen;
  wire [10:0] drive_oe = {pe_oe, pd_oe};

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (hit_pd_data) rd_mux[7:0] = pd_data;
    if (hit_pd_dir) rd_mux[7:0] = pd_dir;
    if (hit_pd_pin) rd_mux[7:0] = pd_pin;
    if (hit_pe_data) rd_mux[2:0] = pe_data;
    if (hit_pe_dir) rd_mux[2:0] = pe_dir;
    if (hit_pe_pin) rd_mux[2:0] = pe_pin;
    if (hit_ctrl) rd_mux[2:0] = ctrl;
    if (hit_drive) rd_mux[10:0] = drive_oe;
  end

  // read data captured in setup so it comes from a flip-flop in the access phase
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
      pd_out <= 8'h00;
      pd_oe <= 8'h00;
      pd_pullup <= 8'h00;
      pe_out <= 3'h0;
      pe_oe <= 3'h0;
      pe_pullup <= 3'h0;
      ser0_rx_line <= 1'b0;
      ser0_ext_clk_in <= 1'b0;
      ser1_ext_clk_in <= 1'b0;
      ext_irq0 <= 1'b0;
      ext_irq1 <= 1'b0;
      ext_irq2 <= 1'b0;
      t1_capture_in <= 1'b0;
      t3_capture_in <= 1'b0;
      xtal_osc_connect <= 1'b0;
    end else begin
      if (setup_ph && !pwrite) prdata <= rd_mux;
      pd_out <= next_pd_out;
      pd_oe <= next_pd_oe;
      pd_pullup <= next_pd_pullup;
      pe_out <= next_pe_out;
      pe_oe <= next_pe_oe;
      pe_pullup <= next_pe_pullup;
      ser0_rx_line <= ser0_rx_enable ? pd_pin[pdo_pkg::PD_RX] : 1'b1;
      ser0_ext_clk_in <= ser0_sync_mode && !pd_dir[pdo_pkg::PD_OSC_IN]
                         && pd_pin[pdo_pkg::PD_OSC_IN];
      ser1_ext_clk_in <= ser1_sync_mode && !pd_dir[pdo_pkg::PD_IRQ0]
                         && pd_pin[pdo_pkg::PD_IRQ0];
      ext_irq0 <= pd_pin[pdo_pkg::PD_IRQ0];
      ext_irq1 <= pd_pin[pdo_pkg::PD_IRQ1];
      t3_capture_in <= pd_pin[pdo_pkg::PD_IRQ1];
      ext_irq2 <= pe_pin[pdo_pkg::PE_IRQ2];
      t1_capture_in <= pe_pin[pdo_pkg::PE_IRQ2];
      xtal_osc_connect <= async_timer2_clk;
    end
  end

  assign pready = 1'b1;
  assign pslverr = access_ph && !hit_any;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  osc_pins_a: assert property (async_timer2_clk |=> !pd_oe[5] && !pd_oe[4] && xtal_osc_connect
    && !pd_pullup[5] && !pd_pullup[4]) else $error("oscillator pins not released");
  osc_inen_a: assert property (async_timer2_clk |-> pd_pin[5:4] == 2'h0)
    else $error("oscillator pins still read digitally");
  mem_strobe_a: assert property (ext_mem_enable |=> pd_oe[7:6] == 2'h3 && pd_pullup[7:6] == 2'h0
    && pd_out[7] == $past(mem_rd_strobe) && pe_out[1] == $past(mem_ale))
    else $error("memory strobes not driven");
  cmp_a_a: assert property (t1_cmp_a_en && !async_timer2_clk |=> pd_out[5] == $past(t1_cmp_a_out)
    && pd_oe[5] == $past(pd_dir[5])) else $error("compare a not on d5");
  d4_prio_a: assert property (ser0_sync_mode && pd_dir[4] && t3_cmp_a_en
    |=> pd_out[4] == $past(ser0_ext_clk_out)) else $error("serial clock lost priority");
  tx_force_a: assert property (ser0_tx_enable && !$past(ser0_tx_enable) |=> pd_oe[1]
    && !pd_pullup[1] && pd_out[1] == $past(ser0_tx_line)) else $error("tx pin not forced");
  rx_force_a: assert property (ser0_rx_enable |=> !pd_oe[0]
    && pd_pullup[0] == ($past(pd_data[0]) && !$past(global_pullup_term)))
    else $error("rx pin pull-up wrong");
  irq_keep_a: assert property (##1 pd_oe[3:2] == $past(pd_dir[3:2]) && pe_oe[2] == $past(pe_dir[2])
    && pe_oe[0] == $past(pe_dir[0])) else $error("direction overridden");
  cmp_b_a: assert property (t1_cmp_b_en |=> pe_out[2] == $past(t1_cmp_b_out))
    else $error("compare b not on e2");
  irq_path_a: assert property (ext_irq2_en |=> ext_irq2 == $past(pe_sync[pdo_pkg::PE_IRQ2])
    && t1_capture_in == $past(pe_sync[pdo_pkg::PE_IRQ2]))
    else $error("e0 capture path split");

endmodule

// ---- testbench/pdo_pad_model.sv ----
// board model on the port d and port e pads
// assumes pad controls are active high and change only on mclk
`timescale 1ns/1ns
module pdo_pad_model (
  input wire logic mclk,
  input wire logic [7:0] pd_out,
  input wire logic [7:0] pd_oe,
  input wire logic [7:0] pd_pullup,
  input wire logic [2:0] pe_out,
  input wire logic [2:0] pe_oe,
  input wire logic [2:0] pe_pullup,
  input wire logic [10:0] drv_en,
  input wire logic [10:0] drv_val,
  output logic [7:0] pd_in,
  output logic [2:0] pe_in
);
  logic [10:0] flt = 11'h000;
  logic [10:0] oe;
  logic [10:0] lvl;
  assign oe = {pe_oe, pd_oe};
  // an undriven line without pull-up wanders, so no test may lean on its last level
  always @(posedge mclk) flt <= ~flt;
  assign lvl = (oe & {pe_out, pd_out}) | (~oe & drv_en & drv_val)
    | (~oe & ~drv_en & ({pe_pullup, pd_pullup} | flt));
  assign pd_in = lvl[7:0];
  assign pe_in = lvl[10:8];
endmodule

// ---- testbench/tb_port_d_e_alt_function_override.sv ----
// self-checking bench for the port d / port e override block
// assumes a zero-wait apb slave and pad controls one edge behind their causes
`timescale 1ns/1ns
module tb_port_d_e_alt_function_override;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, se;
  logic [18:0] pc = 19'h0;
  wire [8:0] po;
  logic [10:0] de = 11'h0, dv = 11'h0;
  logic [7:0] pd_in, pd_out, pd_oe, pd_pullup;
  logic [2:0] pe_in, pe_out, pe_oe, pe_pullup;
  int err_count = 0;
  int n_checks = 0;
  pdo_port_de u_pdo_port_de (.mclk(mclk), .arst_n(arst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_rd_strobe(pc[0]), .mem_wr_strobe(pc[1]), .mem_ale(pc[2]),
    .t1_cmp_a_en(pc[3]), .t1_cmp_a_out(pc[4]), .t1_cmp_b_en(pc[5]), .t1_cmp_b_out(pc[6]),
    .t3_cmp_a_en(pc[7]), .t3_cmp_a_out(pc[8]), .ser0_sync_mode(pc[9]),
    .ser0_ext_clk_out(pc[10]), .ser1_sync_mode(pc[11]), .ser1_ext_clk_out(pc[12]),
    .ser0_tx_enable(pc[13]), .ser0_tx_line(pc[14]), .ser0_rx_enable(pc[15]),
    .ext_irq0_en(pc[16]), .ext_irq1_en(pc[17]), .ext_irq2_en(pc[18]), .ser0_rx_line(po[0]),
    .ser0_ext_clk_in(po[1]), .ser1_ext_clk_in(po[2]), .ext_irq0(po[3]), .ext_irq1(po[4]),
    .ext_irq2(po[5]), .t1_capture_in(po[6]), .t3_capture_in(po[7]),
    .xtal_osc_connect(po[8]), .pd_in(pd_in), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_pullup(pd_pullup), .pe_in(pe_in), .pe_out(pe_out), .pe_oe(pe_oe),
    .pe_pullup(pe_pullup));
  pdo_pad_model u_pdo_pad_model (.mclk(mclk), .pd_out(pd_out), .pd_oe(pd_oe),
    .pd_pullup(pd_pullup), .pe_out(pe_out), .pe_oe(pe_oe), .pe_pullup(pe_pullup),
    .drv_en(de), .drv_val(dv), .pd_in(pd_in), .pe_in(pe_in));
  task automatic end_sim();
    if (err_count == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      err_count++;
      $display("Error pready expected 1 seen %b", pready);
      end_sim();
    end
    rd = prdata;
    se = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // pads and peripheral inputs lag the last write by up to four edges; five leaves margin
  task automatic cfg(input logic [2:0] c, input logic [7:0] d, input logic [7:0] dd,
      input logic [2:0] e, input logic [2:0] ed, input logic [18:0] p,
      input logic [10:0] ben, input logic [10:0] bval);
    @(posedge mclk);
    pc <= p;
    de <= ben;
    dv <= bval;
    apb(1'b1, pdo_pkg::OFS_CTRL, 32'(c));
    apb(1'b1, pdo_pkg::OFS_PD_DATA, 32'(d));
    apb(1'b1, pdo_pkg::OFS_PD_DIR, 32'(dd));
    apb(1'b1, pdo_pkg::OFS_PE_DATA, 32'(e));
    apb(1'b1, pdo_pkg::OFS_PE_DIR, 32'(ed));
    repeat (5) @(posedge mclk);
    #1;
  endtask
  task automatic cp(input logic [23:0] d, input logic [8:0] e);
    chk("pd", 32'({pd_out, pd_oe, pd_pullup}), 32'(d));
    chk("pe", 32'({pe_out, pe_oe, pe_pullup}), 32'(e));
  endtask
  task automatic t_rst();
    cp(24'h0, 9'h0);
    for (int a = 0; a < 8; a++) begin
      if (a != 2 && a != 5) begin
        apb(1'b0, 12'(a * 4), 32'h0);
        chk("reg", rd, 32'h0);
      end
    end
    apb(1'b0, 12'h020, 32'h0);
    chk("unmapped", 32'({rd, se}), 32'h1);
    apb(1'b1, pdo_pkg::OFS_PD_DIR, 32'hFFFFFF5A);
    apb(1'b0, pdo_pkg::OFS_PD_DIR, 32'h0);
    chk("dir", rd, 32'h5A);
  endtask
  task automatic t_mem();
    cfg(3'h1, 8'hC0, 8'h00, 3'h2, 3'h0, 19'h1, 11'h0, 11'h0);
    cp(24'h80C000, 9'h010);
    apb(1'b0, pdo_pkg::OFS_DRIVE, 32'h0);
    chk("drive", rd, 32'h2C0);
    cfg(3'h1, 8'hC0, 8'h00, 3'h2, 3'h0, 19'h6, 11'h0, 11'h0);
    cp(24'h40C000, 9'h090);
  endtask
  task automatic t_osc();
    cfg(3'h2, 8'h30, 8'h20, 3'h0, 3'h0, 19'h18, 11'h030, 11'h030);
    chk("osc", 32'({po[8], pd_oe, pd_pullup}), 32'h10000);
    apb(1'b0, pdo_pkg::OFS_PD_PIN, 32'h0);
    chk("pin", rd & 32'h30, 32'h0);
  endtask
  task automatic t_cmp();
    cfg(3'h0, 8'h00, 8'h30, 3'h0, 3'h0, 19'h398, 11'h0, 11'h0);
    cp(24'h203000, 9'h0);
    cfg(3'h0, 8'h00, 8'h30, 3'h0, 3'h0, 19'h198, 11'h0, 11'h0);
    cp(24'h303000, 9'h0);
    cfg(3'h0, 8'h00, 8'h00, 3'h0, 3'h0, 19'h398, 11'h010, 11'h010);
    chk("clk0", 32'({po[1], pd_oe}), 32'h100);
  endtask
  task automatic t_ser1();
    cfg(3'h0, 8'h00, 8'h04, 3'h0, 3'h0, 19'h1800, 11'h0, 11'h0);
    cp(24'h040400, 9'h0);
    cfg(3'h0, 8'h04, 8'h00, 3'h0, 3'h0, 19'h0800, 11'h004, 11'h004);
    chk("clk1", 32'({po[2], pd_oe, pd_pullup}), 32'h10004);
  endtask
  task automatic t_txrx();
    cfg(3'h0, 8'h03, 8'h01, 3'h0, 3'h0, 19'hA000, 11'h001, 11'h000);
    chk("txrx", 32'({pd_out[1], pd_oe, pd_pullup, po[0]}), 32'h402);
    cfg(3'h4, 8'h03, 8'h01, 3'h0, 3'h0, 19'hE000, 11'h001, 11'h001);
    chk("txrx", 32'({pd_out[1], pd_oe, pd_pullup, po[0]}), 32'h20401);
  endtask
  task automatic t_irq();
    cfg(3'h0, 8'h00, 8'h00, 3'h0, 3'h0, 19'h70000, 11'h10C, 11'h108);
    chk("irq", 32'(po[7:3]), 32'h1E);
    cfg(3'h0, 8'h00, 8'h00, 3'h0, 3'h0, 19'h70000, 11'h10C, 11'h004);
    chk("irq", 32'(po[7:3]), 32'h01);
  endtask
  task automatic t_cmpb();
    cfg(3'h0, 8'h00, 8'h00, 3'h1, 3'h5, 19'h60, 11'h0, 11'h0);
    cp(24'h0, 9'h168);
    cfg(3'h0, 8'h00, 8'h00, 3'h5, 3'h5, 19'h20, 11'h0, 11'h0);
    cp(24'h0, 9'h068);
    cfg(3'h0, 8'h00, 8'h00, 3'h5, 3'h0, 19'h60, 11'h0, 11'h0);
    cp(24'h0, 9'h145);
  endtask
  initial begin
    forever #50 mclk = ~mclk;
  end
  initial begin
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    t_rst();
    t_mem();
    t_osc();
    t_cmp();
    t_ser1();
    t_txrx();
    t_irq();
    t_cmpb();
    end_sim();
  end
endmodule
